// ==== test_timer_sixteen_bit_access_trigger.sv ====
// self-checking bench for the timer with wide access and trigger reset
`timescale 1ns/1ps
module test_timer_sixteen_bit_access_trigger
	import tsat_pkg::*;
;
	logic clock_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [TSAT_ADDR_W-1:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic adc_en = 1'b0;
	logic [7:0] rdata;
	logic pin;
	logic adc_start;
	logic irq;
	int error_cnt = 0;
	int check_count = 0;
	int n;
	always #2.5 clock_in = ~clock_in;
	tsat_timer u_tsat_timer (.clock_in(clock_in), .arst_n_in(arst_n_in), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ext_clk_in(pin), .adc_enabled_in(adc_en),
		.adc_start_out(adc_start), .irq_out(irq));
	tsat_pin_model u_tsat_pin_model (.clock_in(clock_in), .pin_out(pin));
	task automatic print_verdict;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock_in);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clock_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_in);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : rd_chk
	// cycles until the next start pulse
	task automatic wait_start(output int cyc);
		cyc = 0;
		do begin
			@(posedge clock_in);
			#1 cyc++;
		end while (adc_start !== 1'b1 && cyc < 200);
		if (adc_start !== 1'b1) begin
			error_cnt++;
			print_verdict();
		end
	endtask : wait_start
	task automatic wait_irq;
		for (int i = 0; i < 100 && irq !== 1'b1; i++) @(posedge clock_in);
		if (irq !== 1'b1) begin
			error_cnt++;
			print_verdict();
		end
	endtask : wait_irq
	initial begin
		repeat (20) @(posedge clock_in);
		arst_n_in <= 1'b1;
		rd_chk(TSAT_ADDR_FLAG, TSAT_FLAG_RESET);
		rd_chk(TSAT_ADDR_ENABLE, TSAT_ENABLE_RESET);
		rd_chk(TSAT_ADDR_CTRL, TSAT_CTRL_RESET);
		// narrow mode: high address is the live byte
		wr_reg(TSAT_ADDR_LOW, 8'h34);
		wr_reg(TSAT_ADDR_HIGH, 8'h12);
		rd_chk(TSAT_ADDR_HIGH, 8'h12);
		rd_chk(TSAT_ADDR_LOW, 8'h34);
		// wide mode, bit 6 reads zero
		wr_reg(TSAT_ADDR_CTRL, 8'hC0);
		rd_chk(TSAT_ADDR_CTRL, 8'h80);
		wr_reg(TSAT_ADDR_HIGH, 8'hAB);
		rd_chk(TSAT_ADDR_HIGH, 8'hAB);
		rd_chk(TSAT_ADDR_LOW, 8'h34);
		rd_chk(TSAT_ADDR_HIGH, 8'h12);
		wr_reg(TSAT_ADDR_HIGH, 8'hAB);
		wr_reg(TSAT_ADDR_LOW, 8'hCD);
		wr_reg(TSAT_ADDR_CTRL, 8'h00);
		rd_chk(TSAT_ADDR_HIGH, 8'hAB);
		rd_chk(TSAT_ADDR_LOW, 8'hCD);
		// count bytes survive a second reset
		@(posedge clock_in);
		arst_n_in <= 1'b0;
		repeat (2) @(posedge clock_in);
		arst_n_in <= 1'b1;
		rd_chk(TSAT_ADDR_HIGH, 8'hAB);
		rd_chk(TSAT_ADDR_LOW, 8'hCD);
		// wrap sets the flag, the request follows the enable
		wr_reg(TSAT_ADDR_LOW, 8'hF0);
		wr_reg(TSAT_ADDR_HIGH, 8'hFF);
		wr_reg(TSAT_ADDR_ENABLE, 8'h01);
		wr_reg(TSAT_ADDR_CTRL, 8'h01);
		wait_irq();
		rd_chk(TSAT_ADDR_FLAG, 8'h01);
		wr_reg(TSAT_ADDR_ENABLE, 8'h00);
		#1 chk({7'h00, irq}, 8'h00);
		wr_reg(TSAT_ADDR_CTRL, 8'h00);
		rd_chk(TSAT_ADDR_HIGH, 8'h00);
		wr_reg(TSAT_ADDR_FLAG, 8'h00);
		rd_chk(TSAT_ADDR_FLAG, 8'h00);
		// trigger reset, compare pair sets the period
		wr_reg(TSAT_ADDR_LOW, 8'h00);
		wr_reg(TSAT_ADDR_CMP_LOW, 8'h10);
		wr_reg(TSAT_ADDR_CMP_HIGH, 8'h00);
		wr_reg(TSAT_ADDR_CMP_MODE, {4'h0, TSAT_MODE_SPECIAL});
		adc_en <= 1'b1;
		wr_reg(TSAT_ADDR_CTRL, 8'h01);
		wait_start(n);
		@(posedge clock_in);
		#1 chk({7'h00, adc_start}, 8'h00);
		// counted from the second cycle after a pulse, so 17 states show as 16
		wait_start(n);
		chk(n[7:0], 8'h10);
		rd_chk(TSAT_ADDR_FLAG, 8'h00);
		@(posedge clock_in);
		adc_en <= 1'b0;
		n = 0;
		repeat (40) begin
			@(posedge clock_in);
			#1 if (adc_start === 1'b1) n++;
		end
		chk(n[7:0], 8'h00);
		// asynchronous mode ignores the trigger, a low write beats it
		wr_reg(TSAT_ADDR_CTRL, 8'h06);
		wr_reg(TSAT_ADDR_LOW, 8'h10);
		rd_chk(TSAT_ADDR_LOW, 8'h10);
		@(posedge clock_in);
		addr <= TSAT_ADDR_CTRL;
		wdata <= 8'h00;
		wr <= 1'b1;
		@(posedge clock_in);
		addr <= TSAT_ADDR_LOW;
		wdata <= 8'h22;
		@(posedge clock_in);
		wr <= 1'b0;
		rd_chk(TSAT_ADDR_LOW, 8'h22);
		// synchronised external count
		wr_reg(TSAT_ADDR_CMP_MODE, 8'h00);
		wr_reg(TSAT_ADDR_CTRL, 8'h00);
		wr_reg(TSAT_ADDR_LOW, 8'h00);
		wr_reg(TSAT_ADDR_CTRL, 8'h03);
		u_tsat_pin_model.pulses(5);
		repeat (8) @(posedge clock_in);
		wr_reg(TSAT_ADDR_CTRL, 8'h00);
		rd_chk(TSAT_ADDR_LOW, 8'h05);
		print_verdict();
	end
endmodule : test_timer_sixteen_bit_access_trigger

// ==== tsat_pin_model.sv ====
// external count pin model for the timer
`timescale 1ns/1ps
module tsat_pin_model (
	// clock
	input wire logic clock_in,
	// count pin
	output logic pin_out
);
	initial pin_out = 1'b0;
	// n rising edges, three cycles high and three low, idle low between bursts
	task automatic pulses(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (3) @(posedge clock_in);
			pin_out <= 1'b1;
			repeat (3) @(posedge clock_in);
			pin_out <= 1'b0;
		end
	endtask : pulses
endmodule : tsat_pin_model

// ==== tsat_pkg.sv ====
// package for the sixteen-bit timer with wide access and trigger reset
package tsat_pkg;
	localparam int unsigned TSAT_ADDR_W = 3;
	localparam logic [2:0] TSAT_ADDR_FLAG = 3'h0;
	localparam logic [2:0] TSAT_ADDR_ENABLE = 3'h1;
	localparam logic [2:0] TSAT_ADDR_LOW = 3'h2;
	localparam logic [2:0] TSAT_ADDR_HIGH = 3'h3;
	localparam logic [2:0] TSAT_ADDR_CTRL = 3'h4;
	localparam logic [2:0] TSAT_ADDR_CMP_LOW = 3'h5;
	localparam logic [2:0] TSAT_ADDR_CMP_HIGH = 3'h6;
	localparam logic [2:0] TSAT_ADDR_CMP_MODE = 3'h7;
	// control and flag field positions
	localparam int unsigned TSAT_BIT_WIDE = 7;
	localparam int unsigned TSAT_BIT_PS_HI = 5;
	localparam int unsigned TSAT_BIT_PS_LO = 4;
	localparam int unsigned TSAT_BIT_OSC = 3;
	localparam int unsigned TSAT_BIT_SYNC_N = 2;
	localparam int unsigned TSAT_BIT_SRC = 1;
	localparam int unsigned TSAT_BIT_ON = 0;
	localparam int unsigned TSAT_BIT_OVF = 0;
	localparam logic [7:0] TSAT_CTRL_MASK = 8'hBF;
	localparam logic [7:0] TSAT_CTRL_RESET = 8'h00;
	localparam logic [7:0] TSAT_FLAG_RESET = 8'h00;
	localparam logic [7:0] TSAT_ENABLE_RESET = 8'h00;
	localparam logic [3:0] TSAT_MODE_SPECIAL = 4'hB;
	localparam logic [7:0] TSAT_BYTE_ZERO = 8'h00;
	localparam logic [15:0] TSAT_COUNT_ZERO = 16'h0000;
	localparam logic [15:0] TSAT_COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] TSAT_COUNT_ONE = 16'h0001;
	localparam logic [2:0] TSAT_PRE_ZERO = 3'h0;
	localparam logic [2:0] TSAT_PRE_ONE = 3'h1;

	typedef struct packed {
		logic [TSAT_ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tsat_bus_t;

	typedef enum logic [1:0] {
		TSAT_SRC_INTERNAL = 2'b00,
		TSAT_SRC_SYNC_EXT = 2'b01,
		TSAT_SRC_ASYNC_EXT = 2'b11
	} tsat_src_t;
endpackage : tsat_pkg

// ==== tsat_sync.sv ====
// three-stage synchroniser for the external count pin
`timescale 1ns/1ps
module tsat_sync
	import tsat_pkg::*;
(
	// clock and reset
	input wire logic clock_in,
	input wire logic arst_n_in,
	// pin side
	input wire logic pin_in,
	// edge output
	output logic rise_out
);
	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic level_r;

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end else begin
			s1_r <= pin_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// level changes once stages two and three agree
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			level_r <= 1'b0;
		end else if (s2_r == s3_r) begin
			level_r <= s3_r;
		end
	end

	assign rise_out = (s2_r == s3_r) && s3_r && !level_r;
endmodule : tsat_sync

// ==== tsat_timer.sv ====
// sixteen-bit timer with wide access buffer and compare trigger reset
`timescale 1ns/1ps
module tsat_timer
	import tsat_pkg::*;
(
	// clock and reset
	input wire logic clock_in,
	input wire logic arst_n_in,
	// register port
	input wire logic [TSAT_ADDR_W-1:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	// external count pin
	input wire logic ext_clk_in,
	// converter
	input wire logic adc_enabled_in,
	output logic adc_start_out,
	// interrupt request toward the core
	output logic irq_out
);
	tsat_bus_t bus;
	logic [7:0] ctrl_r;
	logic [7:0] flag_r;
	logic [7:0] enable_r;
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic [7:0] hbuf_r;
	logic [7:0] cmp_low_r;
	logic [7:0] cmp_high_r;
	logic [3:0] cmp_mode_r;
	logic [2:0] pre_r;
	logic [7:0] rdata_r;
	logic adc_start_r;
	logic ext_rise;
	logic tick;
	logic wrap;
	logic trig;
	logic trig_ok;
	logic wide;
	logic wr_low;
	logic wr_high;
	logic rd_low;
	tsat_src_t src;

	assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

	function automatic logic hit(input tsat_bus_t b, input logic [2:0] a);
		hit = b.addr == a;
	endfunction : hit

	// prescale terminal value for ratio 1, 2, 4 or 8
	function automatic logic [2:0] pre_last(input logic [1:0] sel);
		pre_last = 3'((4'h1 << sel) - 4'h1);
	endfunction : pre_last

	tsat_sync u_sync (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.pin_in(ext_clk_in),
		.rise_out(ext_rise)
	);

	assign wide = ctrl_r[TSAT_BIT_WIDE];
	assign wr_low = bus.wr && hit(bus, TSAT_ADDR_LOW);
	assign wr_high = bus.wr && hit(bus, TSAT_ADDR_HIGH);
	assign rd_low = bus.rd && hit(bus, TSAT_ADDR_LOW);

	always_comb begin
		if (!ctrl_r[TSAT_BIT_SRC]) begin
			src = TSAT_SRC_INTERNAL;
		end else if (!ctrl_r[TSAT_BIT_SYNC_N]) begin
			src = TSAT_SRC_SYNC_EXT;
		end else begin
			src = TSAT_SRC_ASYNC_EXT;
		end
	end

	// count enable before prescaling
	logic pre_in;
	always_comb begin
		unique case (src)
			TSAT_SRC_INTERNAL: pre_in = ctrl_r[TSAT_BIT_ON];
			TSAT_SRC_SYNC_EXT: pre_in = ctrl_r[TSAT_BIT_ON] && ext_rise;
			TSAT_SRC_ASYNC_EXT: pre_in = ctrl_r[TSAT_BIT_ON] && ext_rise;
			default: pre_in = 1'b0;
		endcase
	end

	assign tick = pre_in && (pre_r == pre_last({ctrl_r[TSAT_BIT_PS_HI], ctrl_r[TSAT_BIT_PS_LO]}));
	assign wrap = tick && (count_r == TSAT_COUNT_MAX);
	assign trig = (cmp_mode_r == TSAT_MODE_SPECIAL) && ({cmp_high_r, cmp_low_r} == count_r);
	assign trig_ok = trig && (src != TSAT_SRC_ASYNC_EXT);

	// prescaler
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pre_r <= TSAT_PRE_ZERO;
		end else if (wr_low) begin
			pre_r <= TSAT_PRE_ZERO;
		end else if (tick) begin
			pre_r <= TSAT_PRE_ZERO;
		end else if (pre_in) begin
			pre_r <= pre_r + TSAT_PRE_ONE;
		end
	end

	always_comb begin
		count_nxt = count_r;
		if (wr_low) begin
			count_nxt = wide ? {hbuf_r, bus.wdata} : {count_r[15:8], bus.wdata};
		end else if (wr_high && !wide) begin
			count_nxt = {bus.wdata, count_r[7:0]};
		end else if (trig_ok) begin
			count_nxt = TSAT_COUNT_ZERO;
		end else if (tick) begin
			count_nxt = count_r + TSAT_COUNT_ONE;
		end
	end

	// count has no reset: it keeps its value across the asynchronous reset, while the compare trigger reset clears it
	always_ff @(posedge clock_in) begin
		count_r <= count_nxt;
	end

	// high byte buffer, also without reset
	always_ff @(posedge clock_in) begin
		if (wide && rd_low) begin
			hbuf_r <= count_r[15:8];
		end else if (wide && wr_high) begin
			hbuf_r <= bus.wdata;
		end
	end

	// control and compare registers
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl_r <= TSAT_CTRL_RESET;
			enable_r <= TSAT_ENABLE_RESET;
			cmp_low_r <= TSAT_BYTE_ZERO;
			cmp_high_r <= TSAT_BYTE_ZERO;
			cmp_mode_r <= TSAT_MODE_SPECIAL ^ TSAT_MODE_SPECIAL;
		end else if (bus.wr) begin
			if (hit(bus, TSAT_ADDR_CTRL)) begin
				ctrl_r <= bus.wdata & TSAT_CTRL_MASK;
			end
			if (hit(bus, TSAT_ADDR_ENABLE)) begin
				enable_r <= bus.wdata;
			end
			if (hit(bus, TSAT_ADDR_CMP_LOW)) begin
				cmp_low_r <= bus.wdata;
			end
			if (hit(bus, TSAT_ADDR_CMP_HIGH)) begin
				cmp_high_r <= bus.wdata;
			end
			if (hit(bus, TSAT_ADDR_CMP_MODE)) begin
				cmp_mode_r <= bus.wdata[3:0];
			end
		end
	end

	// overflow flag: set wins over software clear, trigger never sets it
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			flag_r <= TSAT_FLAG_RESET;
		end else begin
			if (bus.wr && hit(bus, TSAT_ADDR_FLAG)) begin
				flag_r <= bus.wdata;
			end
			if (wrap && !wr_low && !(wr_high && !wide)) begin
				flag_r[TSAT_BIT_OVF] <= 1'b1;
			end
		end
	end

	assign irq_out = flag_r[TSAT_BIT_OVF] && enable_r[TSAT_BIT_OVF];

	// conversion start pulse
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			adc_start_r <= 1'b0;
		end else begin
			adc_start_r <= trig_ok && !wr_low && !(wr_high && !wide) && adc_enabled_in && !adc_start_r;
		end
	end
	assign adc_start_out = adc_start_r;

	// read data, one cycle after the strobe
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_r <= TSAT_BYTE_ZERO;
		end else if (bus.rd) begin
			unique case (bus.addr)
				TSAT_ADDR_FLAG: rdata_r <= flag_r;
				TSAT_ADDR_ENABLE: rdata_r <= enable_r;
				TSAT_ADDR_LOW: rdata_r <= count_r[7:0];
				TSAT_ADDR_HIGH: rdata_r <= wide ? hbuf_r : count_r[15:8];
				TSAT_ADDR_CTRL: rdata_r <= ctrl_r;
				TSAT_ADDR_CMP_LOW: rdata_r <= cmp_low_r;
				TSAT_ADDR_CMP_HIGH: rdata_r <= cmp_high_r;
				TSAT_ADDR_CMP_MODE: rdata_r <= {4'h0, cmp_mode_r};
			endcase
		end else begin
			rdata_r <= TSAT_BYTE_ZERO;
		end
	end
	assign rdata_out = rdata_r;

	// assertions
	a_trig_clears_count: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		trig_ok && !wr_low && !wr_high |=> count_r == TSAT_COUNT_ZERO)
		else $error("trigger did not clear count");
	a_write_beats_trig: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		wr_low && trig_ok && !wide |=> count_r[7:0] == $past(bus.wdata))
		else $error("write lost to trigger");
	a_low_read_copies: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		rd_low && wide |=> hbuf_r == $past(count_r[15:8]))
		else $error("buffer not loaded on low read");
	a_wide_low_write: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		wr_low && wide |=> count_r == {$past(hbuf_r), $past(bus.wdata)})
		else $error("wide write not atomic");
	a_high_write_buffered: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		wr_high && wide && !trig_ok && !tick |=> count_r == $past(count_r))
		else $error("live high byte written in wide mode");
	a_high_keeps_pre: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		wr_high && !pre_in |=> pre_r == $past(pre_r))
		else $error("high write touched prescaler");
	a_low_clears_pre: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		wr_low |=> pre_r == TSAT_PRE_ZERO)
		else $error("low write kept prescaler");
	a_wrap_sets_flag: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		wrap && !wr_low && !(wr_high && !wide) |=> flag_r[TSAT_BIT_OVF])
		else $error("wrap did not set flag");
	a_flag_sticky: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		flag_r[TSAT_BIT_OVF] && !(bus.wr && hit(bus, TSAT_ADDR_FLAG)) |=> flag_r[TSAT_BIT_OVF])
		else $error("overflow flag dropped");
	a_flag_write: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		bus.wr && hit(bus, TSAT_ADDR_FLAG) && !wrap |=> flag_r == $past(bus.wdata))
		else $error("flag write lost");
	a_irq_needs_enable: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		!enable_r[TSAT_BIT_OVF] |-> !irq_out)
		else $error("request without enable");
	a_irq_from_flag: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		flag_r[TSAT_BIT_OVF] && enable_r[TSAT_BIT_OVF] |-> irq_out)
		else $error("enabled flag gave no request");

	// trigger and conversion start
	a_async_no_trig: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		src == TSAT_SRC_ASYNC_EXT |-> !trig_ok)
		else $error("trigger taken in asynchronous mode");
	a_trig_no_flag: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		trig_ok && !wrap && !(bus.wr && hit(bus, TSAT_ADDR_FLAG)) && !flag_r[TSAT_BIT_OVF] |=> !flag_r[TSAT_BIT_OVF])
		else $error("trigger set the flag");
	a_trig_match: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		trig |-> count_r == {cmp_high_r, cmp_low_r})
		else $error("trigger without period match");
	a_start_after_trig: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		adc_start_out |-> $past(trig_ok) && $past(adc_enabled_in))
		else $error("start without trigger");
	a_start_needs_enable: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		!adc_enabled_in |=> !adc_start_out)
		else $error("start while converter disabled");
	a_write_beats_start: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		wr_low |=> !adc_start_out)
		else $error("start despite low write");

	// counting and prescaler
	a_count_steps_one: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		tick && !trig_ok && !wr_low && !(wr_high && !wide) |=> count_r == $past(count_r) + TSAT_COUNT_ONE)
		else $error("count did not step by one");
	a_wrap_to_zero: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		wrap && !trig_ok && !wr_low && !(wr_high && !wide) |=> count_r == TSAT_COUNT_ZERO)
		else $error("count did not wrap to zero");
	a_off_no_tick: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		!ctrl_r[TSAT_BIT_ON] |-> !tick)
		else $error("tick while stopped");
	a_src_internal: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		!ctrl_r[TSAT_BIT_SRC] |-> src == TSAT_SRC_INTERNAL)
		else $error("wrong clock source decode");
	a_pre_holds: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		!pre_in && !wr_low |=> pre_r == $past(pre_r))
		else $error("prescaler moved without cause");
	a_pre_tick_zero: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		tick && !wr_low |=> pre_r == TSAT_PRE_ZERO)
		else $error("prescaler not restarted on tick");

	// register access, and the single-cycle conversion start
	a_narrow_high_write: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		wr_high && !wide |=> count_r[15:8] == $past(bus.wdata))
		else $error("narrow high write not live");
	a_wide_high_buffer: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		wr_high && wide |=> hbuf_r == $past(bus.wdata))
		else $error("wide high write missed buffer");
	a_read_wide_high: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		bus.rd && hit(bus, TSAT_ADDR_HIGH) && wide |=> rdata_out == $past(hbuf_r))
		else $error("wide high read not buffered");
	a_read_low_live: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		bus.rd && hit(bus, TSAT_ADDR_LOW) |=> rdata_out == $past(count_r[7:0]))
		else $error("low read not live");
	a_read_ctrl: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		bus.rd && hit(bus, TSAT_ADDR_CTRL) |=> rdata_out == $past(ctrl_r))
		else $error("control read wrong");
	a_rdata_idle: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		!bus.rd |=> rdata_out == TSAT_BYTE_ZERO)
		else $error("read data not idle");
	a_ctrl_write: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		bus.wr && hit(bus, TSAT_ADDR_CTRL) |=> ctrl_r == ($past(bus.wdata) & TSAT_CTRL_MASK))
		else $error("control write lost");
	a_ctrl_unused_zero: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		1'b1 |-> (ctrl_r & ~TSAT_CTRL_MASK) == TSAT_BYTE_ZERO)
		else $error("unused control bit set");
	a_enable_write: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		bus.wr && hit(bus, TSAT_ADDR_ENABLE) |=> enable_r == $past(bus.wdata))
		else $error("enable write lost");
	a_cmp_low_write: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		bus.wr && hit(bus, TSAT_ADDR_CMP_LOW) |=> cmp_low_r == $past(bus.wdata))
		else $error("compare low write lost");
	a_cmp_high_write: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		bus.wr && hit(bus, TSAT_ADDR_CMP_HIGH) |=> cmp_high_r == $past(bus.wdata))
		else $error("compare high write lost");
	a_cmp_mode_write: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		bus.wr && hit(bus, TSAT_ADDR_CMP_MODE) |=> cmp_mode_r == $past(bus.wdata[3:0]))
		else $error("compare mode write lost");
	a_start_single: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		adc_start_out |=> !adc_start_out)
		else $error("conversion start longer than one cycle");
	a_read_narrow_high: assert property (@(posedge clock_in) disable iff (!arst_n_in)
		bus.rd && hit(bus, TSAT_ADDR_HIGH) && !wide |=> rdata_out == $past(count_r[15:8]))
		else $error("narrow high read not live");
endmodule : tsat_timer
